// ---- src/gpio_defines.vh ----
`ifndef GPIO_DEFINES_VH
`define GPIO_DEFINES_VH

// =============================================================
// Port indices on the internal register access port
`define GPIO_PORT_A      3'h0
`define GPIO_PORT_B      3'h1
`define GPIO_PORT_C      3'h2
`define GPIO_PORT_E      3'h3
`define GPIO_PORT_F      3'h4
`define GPIO_PORT_G      3'h5
`define GPIO_PORT_L      3'h6
`define GPIO_NUM_PORTS   7

// =============================================================
// Register selects within a port
`define GPIO_SEL_CFG     2'h0
`define GPIO_SEL_DATA    2'h1
`define GPIO_SEL_PIN     2'h2

// =============================================================
// Port G special bit positions
`define GPIO_G_WDOG_BIT  1
`define GPIO_G_IN_BIT    6
`define GPIO_G_CLK_BIT   7
`define GPIO_G_IDLE_BIT  6
`define GPIO_G_HALT_BIT  7
`define GPIO_G_ALTSK_BIT 6
`define GPIO_G_CKDLY_BIT 7

// =============================================================
// Reset values and widths
`define GPIO_CFG_RST     8'h00
`define GPIO_DATA_RST    8'h00
`define GPIO_F_WIDTH     4

`endif

// ---- src/gpio_pin_cell.v ----
`include "gpio_defines.vh"

// =============================================================
// One pin: drive and pull-up decode, and a two-stage input synchroniser.
module gpio_pin_cell (
   input  wire i_clk,
   input  wire i_rst_n,
   input  wire i_cfg,
   input  wire i_data,
   input  wire i_pad,
   output wire o_oe,
   output wire o_out,
   output wire o_pu,
   output wire o_level
);
   reg meta;
   reg level;

   assign o_oe    = i_cfg;
   assign o_out   = i_data;
   assign o_pu    = ~i_cfg & i_data;
   assign o_level = level;

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta  <= 1'b0;
         level <= 1'b0;
      end else begin
         meta  <= i_pad;
         level <= meta;
      end
   end
endmodule // gpio_pin_cell

// ---- src/gpio_ports.v ----
// What this block does
// - Each pin's configuration and data bits select hi-Z input, pull-up input, drive low or high.
// - Each port has a configuration, output data and pin input register, 8 bits wide except 4 bits on port F.
// - Six 8-bit ports and one 4-bit port exist, each bit configurable on its own except port G pins 6 and 7, and pin 1 with the watchdog option.
// - Port G pin 6 is always a hi-Z input whatever its register bits hold.
// - With the watchdog option, port G pin 1 carries the watchdog output with pull-up.
// - Without the watchdog option, port G pin 1 is an ordinary I/O pin.
// - Port G pin 7 always drives the oscillator clock.
// - Reading port G data bits 6 and 7 returns zero.
// - Writing one to port G data bit 7 requests HALT mode.
// - Writing one to port G data bit 6 requests IDLE mode.
// - Port G configuration bit 6 selects the alternate serial clock phase, bit 7 the start-up delay.
`include "gpio_defines.vh"

module gpio_ports #(
   parameter NP = `GPIO_NUM_PORTS
) (
   input  wire        I_CORE_CLK,
   input  wire        I_NRST,
   input  wire        I_WR,
   input  wire        I_RD,
   input  wire [2:0]  I_PORT,
   input  wire [1:0]  I_SEL,
   input  wire [7:0]  I_WDATA,
   input  wire        I_WDOG_EN,
   input  wire        I_WDOG_OUT,
   input  wire        I_OSC_CLK,
   input  wire [55:0] I_PAD,
   output reg  [7:0]  O_RDATA,
   output reg  [55:0] O_PAD_OUT,
   output reg  [55:0] O_PAD_OE,
   output reg  [55:0] O_PAD_PU,
   output reg         O_OSC_CLOCK_OUT,
   output reg         O_HALT_REQ,
   output reg         O_IDLE_REQ,
   output reg         O_ALT_SK_PHASE,
   output reg         O_CLK_DELAY_EN
);
   // =============================================================
   // Reset release
   reg rst_meta;
   reg rst_n;
   always @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // =============================================================
   // Register storage, flattened one byte per port
   reg  [8*NP-1:0] cfg;
   reg  [8*NP-1:0] data;
   wire [8*NP-1:0] pin_level;
   wire [8*NP-1:0] cell_oe;
   wire [8*NP-1:0] cell_out;
   wire [8*NP-1:0] cell_pu;
   wire            g_wr;

   assign g_wr = I_WR && (I_PORT == `GPIO_PORT_G) && (I_SEL == `GPIO_SEL_DATA);

   always @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         cfg  <= {NP{`GPIO_CFG_RST}};
         data <= {NP{`GPIO_DATA_RST}};
      end else if (I_WR && I_PORT < NP) begin
         // Port F has only four bits; the upper ones stay zero.
         if (I_SEL == `GPIO_SEL_CFG) begin
            cfg[8*I_PORT +: 8] <= (I_PORT == `GPIO_PORT_F) ?
                                  {4'h0, I_WDATA[3:0]} : I_WDATA;
         end else if (I_SEL == `GPIO_SEL_DATA) begin
            data[8*I_PORT +: 8] <= (I_PORT == `GPIO_PORT_F) ?
                                   {4'h0, I_WDATA[3:0]} : I_WDATA;
         end
      end
   end

   // =============================================================
   // Pin cells, one per bit of every port
   genvar gi;
   generate
      for (gi = 0; gi < 8*NP; gi = gi + 1) begin : g_pin
         gpio_pin_cell u_cell (
            .i_clk   (I_CORE_CLK),
            .i_rst_n (rst_n),
            .i_cfg   (cfg[gi]),
            .i_data  (data[gi]),
            .i_pad   (I_PAD[gi]),
            .o_oe    (cell_oe[gi]),
            .o_out   (cell_out[gi]),
            .o_pu    (cell_pu[gi]),
            .o_level (pin_level[gi])
         );
      end
   endgenerate

   // =============================================================
   // Pad drive with port G overrides
   localparam GB = 8*`GPIO_PORT_G;
   reg [8*NP-1:0] next_oe;
   reg [8*NP-1:0] next_out;
   reg [8*NP-1:0] next_pu;

   always @* begin
      next_oe  = cell_oe;
      next_out = cell_out;
      next_pu  = cell_pu;
      // Unbonded port F bits are never driven.
      next_oe[8*`GPIO_PORT_F+4 +: 4]  = 4'h0;
      next_pu[8*`GPIO_PORT_F+4 +: 4]  = 4'h0;
      next_oe[GB+`GPIO_G_IN_BIT]  = 1'b0;
      next_pu[GB+`GPIO_G_IN_BIT]  = 1'b0;
      next_out[GB+`GPIO_G_IN_BIT] = 1'b0;
      next_oe[GB+`GPIO_G_CLK_BIT]  = 1'b1;
      next_pu[GB+`GPIO_G_CLK_BIT]  = 1'b0;
      next_out[GB+`GPIO_G_CLK_BIT] = I_OSC_CLK;
      if (I_WDOG_EN) begin
         // Output high is left to the pull-up, so the pin acts open drain.
         next_oe[GB+`GPIO_G_WDOG_BIT]  = ~I_WDOG_OUT;
         next_out[GB+`GPIO_G_WDOG_BIT] = 1'b0;
         next_pu[GB+`GPIO_G_WDOG_BIT]  = 1'b1;
      end
   end

   // =============================================================
   // Read mux and registered outputs
   reg [7:0] next_rdata;
   always @* begin
      next_rdata = 8'h00;
      if (I_RD && I_PORT < NP) begin
         case (I_SEL)
            `GPIO_SEL_CFG:  next_rdata = cfg[8*I_PORT +: 8];
            `GPIO_SEL_DATA: next_rdata = data[8*I_PORT +: 8];
            `GPIO_SEL_PIN:  next_rdata = pin_level[8*I_PORT +: 8];
            default:        next_rdata = 8'h00;
         endcase
         if (I_PORT == `GPIO_PORT_G && I_SEL == `GPIO_SEL_DATA) begin
            next_rdata[`GPIO_G_HALT_BIT] = 1'b0;
            next_rdata[`GPIO_G_IDLE_BIT] = 1'b0;
         end
         if (I_PORT == `GPIO_PORT_F) begin
            next_rdata[7:4] = 4'h0;
         end
      end
   end

   always @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_RDATA         <= 8'h00;
         O_PAD_OUT       <= 56'h0;
         O_PAD_OE        <= 56'h0;
         O_PAD_PU        <= 56'h0;
         O_OSC_CLOCK_OUT <= 1'b0;
         O_HALT_REQ      <= 1'b0;
         O_IDLE_REQ      <= 1'b0;
         O_ALT_SK_PHASE  <= 1'b0;
         O_CLK_DELAY_EN  <= 1'b0;
      end else begin
         O_RDATA         <= next_rdata;
         O_PAD_OUT       <= next_out[55:0];
         O_PAD_OE        <= next_oe[55:0];
         O_PAD_PU        <= next_pu[55:0];
         O_OSC_CLOCK_OUT <= I_OSC_CLK;
         // One-cycle request pulses; the data bits themselves read as zero.
         O_HALT_REQ      <= g_wr & I_WDATA[`GPIO_G_HALT_BIT];
         O_IDLE_REQ      <= g_wr & I_WDATA[`GPIO_G_IDLE_BIT];
         O_ALT_SK_PHASE  <= cfg[GB+`GPIO_G_ALTSK_BIT];
         O_CLK_DELAY_EN  <= cfg[GB+`GPIO_G_CKDLY_BIT];
      end
   end
endmodule // gpio_ports

// ---- tb/gpio_ports_props.sv ----
module gpio_ports_props #(
   parameter NP = 7
) (
   input wire        I_CORE_CLK,
   input wire        I_NRST,
   input wire        I_WR,
   input wire        I_RD,
   input wire [2:0]  I_PORT,
   input wire [1:0]  I_SEL,
   input wire [7:0]  I_WDATA,
   input wire        I_WDOG_EN,
   input wire        I_WDOG_OUT,
   input wire        I_OSC_CLK,
   input wire [55:0] I_PAD,
   input wire [7:0]  O_RDATA,
   input wire [55:0] O_PAD_OUT,
   input wire [55:0] O_PAD_OE,
   input wire [55:0] O_PAD_PU,
   input wire        O_OSC_CLOCK_OUT,
   input wire        O_HALT_REQ,
   input wire        O_IDLE_REQ,
   input wire        O_ALT_SK_PHASE,
   input wire        O_CLK_DELAY_EN
);
   timeunit 1ns;
   timeprecision 1ps;
   // The clock copy is only judged once the internal reset has surely lifted.
   logic [1:0] up;
   always @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) up <= 2'h0;
      else if (up != 2'h3) up <= up + 2'h1;
   end
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_NRST);
   // ====
   // Power requests.
   sequence s_halt_wr;
      I_WR && I_PORT == 3'h5 && I_SEL == 2'h1 && I_WDATA[7] ##1 !I_WR;
   endsequence
   sequence s_idle_wr;
      I_WR && I_PORT == 3'h5 && I_SEL == 2'h1 && I_WDATA[6] ##1 !I_WR;
   endsequence
   chk_halt_pulse: assert property (s_halt_wr |-> O_HALT_REQ ##1 !O_HALT_REQ)
      else $error("halt request pulse wrong");
   chk_idle_pulse: assert property (s_idle_wr |-> O_IDLE_REQ ##1 !O_IDLE_REQ)
      else $error("idle request pulse wrong");
   chk_halt_cause: assert property (O_HALT_REQ |->
      $past(I_WR && I_PORT == 3'h5 && I_SEL == 2'h1 && I_WDATA[7]))
      else $error("halt request without cause");
   chk_idle_cause: assert property (O_IDLE_REQ |->
      $past(I_WR && I_PORT == 3'h5 && I_SEL == 2'h1 && I_WDATA[6]))
      else $error("idle request without cause");
   // ====
   // Pins and reads.
   chk_g6_input: assert property (!O_PAD_OE[46] && !O_PAD_PU[46])
      else $error("port G pin 6 not a plain input");
   chk_f_upper: assert property (O_PAD_OE[39:36] == 4'h0)
      else $error("port F upper bits driven");
   chk_osc_copy: assert property (up == 2'h3 |-> O_OSC_CLOCK_OUT == $past(I_OSC_CLK))
      else $error("clock output not a copy");
   chk_g_rd_zero: assert property ($past(I_RD && I_PORT == 3'h5 && I_SEL == 2'h1)
      |-> O_RDATA[7:6] == 2'h0)
      else $error("port G data bits 6 7 not zero");
   chk_idle_rdata: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
      else $error("read data without read");
endmodule // gpio_ports_props

bind gpio_ports gpio_ports_props #(.NP(NP)) gpio_ports_props_i (.*);

// ---- tb/tb_gpio_ports.sv ----
module tb_gpio_ports;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, nrst = 0, wr = 0, rd = 0, wen = 0, wout = 1, osc = 0;
   logic [2:0]  port = 0;
   logic [1:0]  sel = 0;
   logic [7:0]  wd = 0, rdata;
   logic [55:0] pad = 0, pout, poe, ppu;
   logic        osc_clock_out, halt, idle, alt, dly;
   int          fail_count = 0, checked = 0, b;
   // Port, config, data, pad level, then expected enable, drive, pull-up, pin read.
   logic [7:0]  tbl [6][8] = '{'{0, 8'h0f, 8'h55, 8'ha5, 8'h0f, 8'h05, 8'h50, 8'ha5},
      '{1, 8'hf0, 8'h3c, 8'h3c, 8'hf0, 8'h30, 8'h0c, 8'h3c},
      '{2, 8'hff, 8'ha5, 8'h5a, 8'hff, 8'ha5, 8'h00, 8'h5a},
      '{3, 8'h00, 8'hff, 8'hc3, 8'h00, 8'h00, 8'hff, 8'hc3},
      '{4, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h0f, 8'h00, 8'h0f},
      '{6, 8'h5a, 8'h0f, 8'h96, 8'h5a, 8'h0a, 8'h05, 8'h96}};
   gpio_ports gpio_ports_i (.I_CORE_CLK(clk), .I_NRST(nrst), .I_WR(wr), .I_RD(rd),
      .I_PORT(port), .I_SEL(sel), .I_WDATA(wd), .I_WDOG_EN(wen), .I_WDOG_OUT(wout),
      .I_OSC_CLK(osc), .I_PAD(pad), .O_RDATA(rdata), .O_PAD_OUT(pout), .O_PAD_OE(poe),
      .O_PAD_PU(ppu), .O_OSC_CLOCK_OUT(osc_clock_out), .O_HALT_REQ(halt), .O_IDLE_REQ(idle),
      .O_ALT_SK_PHASE(alt), .O_CLK_DELAY_EN(dly));
   always #5 clk = ~clk;
   always @(posedge clk) osc <= #1 ~osc;
   // ====
   // Access tasks.
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic acc(input logic w, input logic [2:0] p, input logic [1:0] s,
                      input logic [7:0] d);
      @(posedge clk) #1;
      wr = w; rd = !w; port = p; sel = s; wd = d;
      @(posedge clk) #1;
      wr = 0; rd = 0;
   endtask
   task automatic rdr(input string n, input logic [2:0] p, input logic [1:0] s,
                      input logic [7:0] e);
      acc(0, p, s, 8'h00);
      chk(n, e, rdata);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ====
   // Sequence.
   initial begin
      repeat (10) @(posedge clk);
      #1 nrst = 1;
      repeat (3) @(posedge clk);
      foreach (tbl[i]) begin
         b = 8 * tbl[i][0];
         pad[b +: 8] = tbl[i][3];
         acc(1, tbl[i][0][2:0], 2'h0, tbl[i][1]);
         acc(1, tbl[i][0][2:0], 2'h1, tbl[i][2]);
         repeat (2) @(posedge clk);
         #1 chk("oe", tbl[i][4], poe[b +: 8]);
         chk("drive", tbl[i][5], pout[b +: 8] & poe[b +: 8]);
         chk("pull", tbl[i][6], ppu[b +: 8]);
         rdr("pin", tbl[i][0][2:0], 2'h2, tbl[i][7]);
      end
      // Software on the smallest package keeps only the bonded port A bits.
      acc(0, 3'h0, 2'h2, 8'h00);
      chk("a_masked", 8'h25, rdata & 8'h3f);
      acc(1, 3'h5, 2'h0, 8'h02);
      acc(1, 3'h5, 2'h1, 8'h02);
      repeat (2) @(posedge clk);
      #1 chk("g_oe", 8'h82, poe[47:40]);
      chk("g_out", 8'h02, pout[47:40] & 8'h02);
      wen = 1;
      repeat (3) @(posedge clk);
      #1 chk("wdog_up", 8'h02, {6'h0, ppu[41], poe[41]});
      wout = 0;
      repeat (3) @(posedge clk);
      #1 chk("wdog_low", 8'h01, {6'h0, pout[41], poe[41]});
      wen = 0;
      acc(1, 3'h5, 2'h1, 8'hc2);
      chk("pwr", 8'h03, {6'h0, halt, idle});
      @(posedge clk) #1;
      chk("pwr_end", 8'h00, {6'h0, halt, idle});
      rdr("g_data", 3'h5, 2'h1, 8'h02);
      acc(1, 3'h5, 2'h0, 8'hc2);
      repeat (2) @(posedge clk);
      #1 chk("g_ctl", 8'h03, {6'h0, dly, alt});
      rdr("unmapped", 3'h7, 2'h0, 8'h00);
      rdr("sel3", 3'h0, 2'h3, 8'h00);
      nrst = 0;
      repeat (2) @(posedge clk);
      #1 nrst = 1;
      repeat (3) @(posedge clk);
      rdr("cfg_rst", 3'h0, 2'h0, 8'h00);
      chk("oe_rst", 8'h00, poe[7:0]);
      wrap_up();
   end
endmodule // tb_gpio_ports
